// ==== design/branch_skip_compare_unit.v ====
// What this block does
// - Flag-set branch jumps to PC+k+1 when chosen flag is one; 1/2 cycles.
// - Flag-clear branch jumps to PC+k+1 when chosen flag is zero; 1/2 cycles.
// - Carry branches jump on carry zero or one; 1/2 cycles.
// - Unsigned ge jumps on carry zero, unsigned lt on carry one.
// - Signed ge jumps when N xor V is zero; 1/2 cycles.
// - Signed lt jumps when N xor V is one; 1/2 cycles.
// - Half-carry-set branch jumps when H is one; 1/2 cycles.
// - Compare-skip-equal skips next instruction on equal registers; 1/2/3 cycles.
// - Register bit skips skip on bit zero or one; 1/2/3 cycles.
// - I/O bit skips skip on I/O bit zero or one; 2/3/4 cycles.
// - Compares subtract without writeback, update Z C N V S H in one cycle.
// - Indirect call loads PC from Z, upper bits zero; 2 or 3 cycles.
// - Extended indirect call takes upper PC bits from extended register; 3 cycles.
// - Half-carry-clear branch jumps when H is zero; 1/2 cycles.
// - Overflow branches jump when V is one or zero; 1/2 cycles.
// - T-bit and interrupt-enable branches test T and I flags likewise.
`timescale 1ns/1ps
`include "flow_unit_defs.vh"

module branch_skip_compare_unit #(
  parameter PC_W    = 22,
  parameter WIDE_PC = 1
) (
  // Clock and reset
  input  wire            sys_clk,
  input  wire            rst,
  // Request from decode
  input  wire            start,
  input  wire [5:0]      op_sel,
  input  wire [PC_W-1:0] pc_in,
  input  wire [6:0]      k_offset,
  input  wire [PC_W-1:0] call_target,
  input  wire [2:0]      bit_sel,
  input  wire            next_two_word,
  output wire            ready,
  // Operands
  input  wire [7:0]      rd_val,
  input  wire [7:0]      rr_val,
  input  wire [7:0]      imm_val,
  input  wire [7:0]      io_val,
  input  wire [7:0]      status_flags_in,
  input  wire [15:0]     z_ptr,
  input  wire [5:0]      extended_indirect_high,
  input  wire [PC_W-1:0] stack_pc,
  // Results
  output wire            done,
  output wire            busy,
  output reg  [PC_W-1:0] pc_out,
  output reg             flags_we,
  output reg  [7:0]      status_flags_out,
  output reg             push_req,
  output reg             pop_req,
  output reg  [PC_W-1:0] ret_addr,
  output reg  [2:0]      cycles_used
);

  reg  [2:0]      cnt_q;
  reg  [2:0]      cnt_d;
  reg             taken;
  reg  [PC_W-1:0] pc_d;
  reg  [2:0]      cyc_d;
  reg             fwe_d;
  reg  [7:0]      flags_d;
  reg             push_d;
  reg             pop_d;
  reg  [PC_W-1:0] ret_d;
  reg             cmp_op;
  reg  [7:0]      opnd;
  reg             borrow_in;

  wire [PC_W-1:0] pc_next;
  wire [PC_W-1:0] pc_branch;
  wire [PC_W-1:0] pc_skip;
  wire [7:0]      diff;
  wire            fc;
  wire            fz;
  wire            fn;
  wire            fv;
  wire            fh;
  wire            ft;
  wire            fi;
  wire            r_c;
  wire            r_h;
  wire            r_v;
  wire            r_z;

  assign fc = status_flags_in[`FLAG_C];
  assign fz = status_flags_in[`FLAG_Z];
  assign fn = status_flags_in[`FLAG_N];
  assign fv = status_flags_in[`FLAG_V];
  assign fh = status_flags_in[`FLAG_H];
  assign ft = status_flags_in[`FLAG_T];
  assign fi = status_flags_in[`FLAG_I];

  // A new request may overlap the final cycle of the previous one
  assign busy  = (cnt_q != 3'h0);
  assign done  = (cnt_q == 3'h1);
  assign ready = (cnt_q <= 3'h1);

  assign pc_next   = pc_in + {{(PC_W-1){1'b0}}, 1'b1};
  assign pc_branch = pc_next + {{(PC_W-7){k_offset[6]}}, k_offset};
  // Skipping a two-word instruction jumps one word further
  assign pc_skip   = pc_in + (next_two_word ? {{(PC_W-2){1'b0}}, 2'h3}
                                            : {{(PC_W-2){1'b0}}, 2'h2});

  // Subtraction shared by the three compares; Rd is never written back
  assign diff = rd_val - opnd - {7'h00, borrow_in};
  assign r_c  = (~rd_val[7] & opnd[7]) | (opnd[7] & diff[7]) | (diff[7] & ~rd_val[7]);
  assign r_h  = (~rd_val[3] & opnd[3]) | (opnd[3] & diff[3]) | (diff[3] & ~rd_val[3]);
  assign r_v  = (rd_val[7] & ~opnd[7] & ~diff[7]) | (~rd_val[7] & opnd[7] & diff[7]);
  // With-carry form keeps Z cleared once a multi-byte compare saw a difference
  assign r_z  = (diff == 8'h00) & (~(op_sel == `OP_COMPARE_WITH_CARRY) | fz);

  always @* begin
    opnd      = (op_sel == `OP_COMPARE_IMMEDIATE) ? imm_val : rr_val;
    borrow_in = (op_sel == `OP_COMPARE_WITH_CARRY) ? fc : 1'b0;
    cmp_op    = (op_sel == `OP_COMPARE_REGS) | (op_sel == `OP_COMPARE_WITH_CARRY) |
                (op_sel == `OP_COMPARE_IMMEDIATE);
  end

  always @* begin
    taken   = 1'b0;
    pc_d    = pc_next;
    cyc_d   = `CYC_ONE;
    fwe_d   = 1'b0;
    flags_d = status_flags_in;
    push_d  = 1'b0;
    pop_d   = 1'b0;
    ret_d   = pc_next;
    case (op_sel)
      `OP_BRANCH_ON_FLAG_SET:      taken = status_flags_in[bit_sel];
      `OP_BRANCH_ON_FLAG_CLEAR:    taken = ~status_flags_in[bit_sel];
      `OP_BRANCH_CARRY_CLEAR:      taken = ~fc;
      `OP_BRANCH_CARRY_SET:        taken = fc;
      `OP_BRANCH_UNSIGNED_GE:      taken = ~fc;
      `OP_BRANCH_UNSIGNED_LT:      taken = fc;
      `OP_BRANCH_SIGNED_GE:        taken = ~(fn ^ fv);
      `OP_BRANCH_SIGNED_LT:        taken = fn ^ fv;
      `OP_BRANCH_HALF_CARRY_SET:   taken = fh;
      `OP_BRANCH_HALF_CARRY_CLEAR: taken = ~fh;
      `OP_BRANCH_OVERFLOW_SET:     taken = fv;
      `OP_BRANCH_OVERFLOW_CLEAR:   taken = ~fv;
      `OP_BRANCH_TBIT_SET:         taken = ft;
      `OP_BRANCH_TBIT_CLEAR:       taken = ~ft;
      `OP_BRANCH_IRQ_ENABLED:      taken = fi;
      `OP_BRANCH_IRQ_DISABLED:     taken = ~fi;
      `OP_BRANCH_ZERO_SET:         taken = fz;
      `OP_BRANCH_ZERO_CLEAR:       taken = ~fz;
      `OP_BRANCH_NEGATIVE:         taken = fn;
      `OP_BRANCH_POSITIVE:         taken = ~fn;
      `OP_COMPARE_SKIP_EQUAL:      taken = (rd_val == rr_val);
      `OP_SKIP_REG_BIT_ZERO:       taken = ~rr_val[bit_sel];
      `OP_SKIP_REG_BIT_ONE:        taken = rr_val[bit_sel];
      `OP_SKIP_IO_BIT_ZERO:        taken = ~io_val[bit_sel];
      `OP_SKIP_IO_BIT_ONE:         taken = io_val[bit_sel];
      default:                     taken = 1'b0;
    endcase

    if (op_sel <= `OP_BRANCH_POSITIVE) begin
      // Taken branch costs one extra cycle to refill fetch
      if (taken) begin
        pc_d  = pc_branch;
        cyc_d = `CYC_TWO;
      end
    end else if (op_sel <= `OP_SKIP_IO_BIT_ONE) begin
      // I/O tests spend one extra cycle reading the I/O space
      cyc_d = ((op_sel == `OP_SKIP_IO_BIT_ZERO) | (op_sel == `OP_SKIP_IO_BIT_ONE)) ?
              `CYC_TWO : `CYC_ONE;
      if (taken) begin
        pc_d  = pc_skip;
        cyc_d = cyc_d + (next_two_word ? `CYC_TWO : `CYC_ONE);
      end
    end else if (cmp_op) begin
      fwe_d              = 1'b1;
      flags_d[`FLAG_C]   = r_c;
      flags_d[`FLAG_Z]   = r_z;
      flags_d[`FLAG_N]   = diff[7];
      flags_d[`FLAG_V]   = r_v;
      flags_d[`FLAG_S]   = diff[7] ^ r_v;
      flags_d[`FLAG_H]   = r_h;
    end else begin
      case (op_sel)
        `OP_INDIRECT_SUBROUTINE_JUMP: begin
          pc_d   = {{(PC_W-16){1'b0}}, z_ptr};
          cyc_d  = (WIDE_PC != 0) ? `CYC_THREE : `CYC_TWO;
          push_d = 1'b1;
        end
        `OP_EXTENDED_INDIRECT_JUMP: begin
          pc_d   = {extended_indirect_high[PC_W-17:0], z_ptr};
          cyc_d  = `CYC_THREE;
          push_d = 1'b1;
        end
        `OP_DIRECT_CALL: begin
          pc_d   = call_target;
          cyc_d  = (WIDE_PC != 0) ? `CYC_FOUR : `CYC_THREE;
          push_d = 1'b1;
          // Call is a two-word instruction
          ret_d  = pc_in + {{(PC_W-2){1'b0}}, 2'h2};
        end
        `OP_SUBROUTINE_EXIT: begin
          pc_d  = stack_pc;
          cyc_d = (WIDE_PC != 0) ? `CYC_FIVE : `CYC_FOUR;
          pop_d = 1'b1;
        end
        `OP_INTERRUPT_EXIT: begin
          pc_d             = stack_pc;
          cyc_d            = (WIDE_PC != 0) ? `CYC_FIVE : `CYC_FOUR;
          pop_d            = 1'b1;
          fwe_d            = 1'b1;
          flags_d[`FLAG_I] = 1'b1;
        end
        default: begin
          pc_d = pc_next;
        end
      endcase
    end
  end

  always @* begin
    cnt_d = cnt_q;
    if (start && ready)
      cnt_d = cyc_d;
    else if (cnt_q != 3'h0)
      cnt_d = cnt_q - 3'h1;
  end

  // Results are latched at acceptance and held until the next request
  always @(posedge sys_clk) begin
    if (rst) begin
      cnt_q            <= 3'h0;
      pc_out           <= {PC_W{1'b0}};
      flags_we         <= 1'b0;
      status_flags_out <= 8'h00;
      push_req         <= 1'b0;
      pop_req          <= 1'b0;
      ret_addr         <= {PC_W{1'b0}};
      cycles_used      <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
      if (start && ready) begin
        pc_out           <= pc_d;
        flags_we         <= fwe_d;
        status_flags_out <= flags_d;
        push_req         <= push_d;
        pop_req          <= pop_d;
        ret_addr         <= ret_d;
        cycles_used      <= cyc_d;
      end
    end
  end

endmodule // branch_skip_compare_unit

// ==== design/flow_unit_defs.vh ====
`ifndef FLOW_UNIT_DEFS_VH
`define FLOW_UNIT_DEFS_VH

// Operation select codes
`define OP_BRANCH_ON_FLAG_SET      6'h00
`define OP_BRANCH_ON_FLAG_CLEAR    6'h01
`define OP_BRANCH_CARRY_CLEAR      6'h02
`define OP_BRANCH_CARRY_SET        6'h03
`define OP_BRANCH_UNSIGNED_GE      6'h04
`define OP_BRANCH_UNSIGNED_LT      6'h05
`define OP_BRANCH_SIGNED_GE        6'h06
`define OP_BRANCH_SIGNED_LT        6'h07
`define OP_BRANCH_HALF_CARRY_SET   6'h08
`define OP_BRANCH_HALF_CARRY_CLEAR 6'h09
`define OP_BRANCH_OVERFLOW_SET     6'h0a
`define OP_BRANCH_OVERFLOW_CLEAR   6'h0b
`define OP_BRANCH_TBIT_SET         6'h0c
`define OP_BRANCH_TBIT_CLEAR       6'h0d
`define OP_BRANCH_IRQ_ENABLED      6'h0e
`define OP_BRANCH_IRQ_DISABLED     6'h0f
`define OP_BRANCH_ZERO_SET         6'h10
`define OP_BRANCH_ZERO_CLEAR       6'h11
`define OP_BRANCH_NEGATIVE         6'h12
`define OP_BRANCH_POSITIVE         6'h13
`define OP_COMPARE_SKIP_EQUAL      6'h14
`define OP_SKIP_REG_BIT_ZERO       6'h15
`define OP_SKIP_REG_BIT_ONE        6'h16
`define OP_SKIP_IO_BIT_ZERO        6'h17
`define OP_SKIP_IO_BIT_ONE         6'h18
`define OP_COMPARE_REGS            6'h19
`define OP_COMPARE_WITH_CARRY      6'h1a
`define OP_COMPARE_IMMEDIATE       6'h1b
`define OP_INDIRECT_SUBROUTINE_JUMP 6'h1c
`define OP_EXTENDED_INDIRECT_JUMP  6'h1d
`define OP_DIRECT_CALL             6'h1e
`define OP_SUBROUTINE_EXIT         6'h1f
`define OP_INTERRUPT_EXIT          6'h20

// Status flag bit positions
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7

// Cycle counts
`define CYC_ONE   3'h1
`define CYC_TWO   3'h2
`define CYC_THREE 3'h3
`define CYC_FOUR  3'h4
`define CYC_FIVE  3'h5

`endif

// ==== bench/flow_unit_sva.sv ====
`timescale 1ns/1ps
`include "flow_unit_defs.vh"
module flow_unit_sva #(
  parameter PC_W    = 22,
  parameter WIDE_PC = 1
) (
  // Clock and reset
  input wire            sys_clk,
  input wire            rst,
  // Request
  input wire            start,
  input wire            ready,
  input wire [5:0]      op_sel,
  input wire [PC_W-1:0] pc_in,
  input wire [6:0]      k_offset,
  input wire [7:0]      status_flags_in,
  input wire [15:0]     z_ptr,
  input wire [5:0]      extended_indirect_high,
  input wire [PC_W-1:0] stack_pc,
  // Results
  input wire            done,
  input wire [PC_W-1:0] pc_out,
  input wire            flags_we,
  input wire [7:0]      status_flags_out,
  input wire            pop_req,
  input wire [2:0]      cycles_used
);
  wire            nv  = status_flags_in[2] ^ status_flags_in[3];
  wire [PC_W-1:0] tgt = pc_in + {{(PC_W-7){k_offset[6]}}, k_offset} + 1'b1;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence take(logic [5:0] op);
    start && ready && op_sel == op;
  endsequence
  a_zero_taken: assert property (take(`OP_BRANCH_ZERO_SET) ##0 status_flags_in[1] |=>
    pc_out == $past(tgt) && cycles_used == 3'h2 ##1 done) else $error("zero branch wrong");
  a_signed_ge_cost: assert property (take(`OP_BRANCH_SIGNED_GE) |=>
    (cycles_used == 3'h2) == !$past(nv)) else $error("signed ge branch decision wrong");
  a_compare_one_cycle: assert property (take(`OP_COMPARE_REGS) |=>
    flags_we && done && cycles_used == 3'h1) else $error("compare timing wrong");
  a_indirect_hi_clear: assert property (take(`OP_INDIRECT_SUBROUTINE_JUMP) |=>
    pc_out == {{(PC_W-16){1'b0}}, $past(z_ptr)} && cycles_used == (WIDE_PC ? 3'h3 : 3'h2))
    else $error("indirect call target wrong");
  a_ext_call_pc: assert property (take(`OP_EXTENDED_INDIRECT_JUMP) |=>
    pc_out == {$past(extended_indirect_high), $past(z_ptr)} ##0 !done [*2] ##1 done)
    else $error("extended call wrong");
  a_io_skip_slow: assert property (start && ready && op_sel > 6'h16 && op_sel < 6'h19 |=>
    !done && cycles_used >= 3'h2) else $error("io skip too fast");
  a_return_pop: assert property (take(`OP_SUBROUTINE_EXIT) ##0 WIDE_PC == 1 |=>
    pop_req && pc_out == $past(stack_pc) ##0 !done [*4] ##1 done) else $error("return wrong");
  a_interrupt_exit_sets_i: assert property (take(`OP_INTERRUPT_EXIT) |=>
    flags_we && status_flags_out[7]) else $error("interrupt exit left I clear");
endmodule // flow_unit_sva

bind branch_skip_compare_unit flow_unit_sva #(.PC_W(PC_W), .WIDE_PC(WIDE_PC)) chk (
  .sys_clk(sys_clk), .rst(rst), .start(start), .ready(ready), .op_sel(op_sel),
  .pc_in(pc_in), .k_offset(k_offset), .status_flags_in(status_flags_in), .z_ptr(z_ptr),
  .extended_indirect_high(extended_indirect_high), .stack_pc(stack_pc), .done(done),
  .pc_out(pc_out), .flags_we(flags_we), .status_flags_out(status_flags_out),
  .pop_req(pop_req), .cycles_used(cycles_used));

// ==== bench/stack_partner.sv ====
`timescale 1ns/1ps
module stack_partner (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // Unit side
  input  wire        start,
  input  wire [5:0]  op_sel,
  input  wire        push_req,
  input  wire [21:0] ret_addr,
  output wire [21:0] stack_pc
);
  reg  [21:0] top_q;
  wire        pop_now = start && (op_sel == 6'h1f || op_sel == 6'h20);
  // One-deep stack; off the pop cycle the bus shows the inverse so stale data never matches
  assign stack_pc = pop_now ? top_q : ~top_q;
  always @(posedge sys_clk) begin
    if (rst) top_q <= 22'h0;
    else if (push_req) top_q <= ret_addr;
  end
endmodule // stack_partner

// ==== bench/branch_skip_compare_unit_bench.sv ====
`timescale 1ns/1ps
`include "flow_unit_defs.vh"
module branch_skip_compare_unit_bench;
  reg          sys_clk, rst, start, next_two_word;
  reg  [5:0]   op_sel, extended_indirect_high;
  reg  [21:0]  pc_in, call_target, top_e;
  reg  [6:0]   k_offset;
  reg  [2:0]   bit_sel;
  reg  [7:0]   rd_val, rr_val, imm_val, io_val, status_flags_in;
  reg  [15:0]  z_ptr;
  wire         ready, done, busy, flags_we, push_req, pop_req;
  wire [21:0]  pc_out, ret_addr, stack_pc;
  wire [7:0]   status_flags_out;
  wire [2:0]   cycles_used;
  integer      errors, n_tests, cyc_n, i, r, seed;
  logic [58:0] q[$];
  localparam logic [17:0] FIDX = {3'h2, 3'h1, 3'h7, 3'h6, 3'h3, 3'h5};
  branch_skip_compare_unit #(.PC_W(22), .WIDE_PC(1)) dut (
    .sys_clk(sys_clk), .rst(rst), .start(start), .op_sel(op_sel), .pc_in(pc_in),
    .k_offset(k_offset), .call_target(call_target), .bit_sel(bit_sel),
    .next_two_word(next_two_word), .ready(ready), .rd_val(rd_val), .rr_val(rr_val),
    .imm_val(imm_val), .io_val(io_val), .status_flags_in(status_flags_in), .z_ptr(z_ptr),
    .extended_indirect_high(extended_indirect_high), .stack_pc(stack_pc), .done(done),
    .busy(busy), .pc_out(pc_out), .flags_we(flags_we), .status_flags_out(status_flags_out),
    .push_req(push_req), .pop_req(pop_req), .ret_addr(ret_addr), .cycles_used(cycles_used));
  stack_partner far (.sys_clk(sys_clk), .rst(rst), .start(start), .op_sel(op_sel),
    .push_req(push_req), .ret_addr(ret_addr), .stack_pc(stack_pc));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task cmp_pc(input string n, input logic [21:0] e, input logic [21:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task cmp_b(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task results;
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task issue(input logic [5:0] op);
    logic [127:0] v;
    logic [8:0] d;
    logic [4:0] h;
    logic [7:0] o2, f;
    logic [2:0] cy;
    logic [21:0] pe;
    logic eq, s, c, ov, pc_ok, fl_ok;
    logic [1:0] pp;
    while (ready !== 1'b1) begin
      start = 1'b0;
      @(negedge sys_clk);
    end
    v = {$random(seed), $random(seed), $random(seed), $random(seed)};
    {eq, extended_indirect_high, z_ptr, status_flags_in, io_val, imm_val, rr_val, rd_val,
      next_two_word, bit_sel, k_offset, call_target, pc_in} = v[117:0];
    if (eq) rr_val = rd_val;
    op_sel = op;
    f = status_flags_in;
    fl_ok = 1'b0;
    pc_ok = 1'b1;
    pe = 22'h0;
    pp = 2'b00;
    if (op < 6'h14) begin
      s = op < 6'h2 ? f[bit_sel] : op < 6'h6 ? f[0] : op < 6'h8 ? f[2] ^ f[3]
        : f[FIDX[3*(op[4:1]-4'h4) +: 3]];
      s = s ^ ((op >= 6'h2 && op < 6'h8) ? !op[0] : op[0]);
      cy = s ? 3'h2 : 3'h1;
      pe = s ? pc_in + {{15{k_offset[6]}}, k_offset} + 22'h1 : pc_in + 22'h1;
    end else if (op < 6'h19) begin
      s = op == `OP_COMPARE_SKIP_EQUAL ? rd_val == rr_val
        : (op < 6'h17 ? rr_val[bit_sel] : io_val[bit_sel]) ^ op[0];
      cy = s ? (next_two_word ? 3'h3 : 3'h2) : 3'h1;
      pe = pc_in + {19'h0, cy};
      cy = cy + {2'h0, op > 6'h16};
    end else if (op < 6'h1c) begin
      o2 = op == `OP_COMPARE_IMMEDIATE ? imm_val : rr_val;
      c = op == `OP_COMPARE_WITH_CARRY && f[0];
      d = {1'b0, rd_val} - {1'b0, o2} - {8'h0, c};
      h = {1'b0, rd_val[3:0]} - {1'b0, o2[3:0]} - {4'h0, c};
      ov = (rd_val[7] & !o2[7] & !d[7]) | (!rd_val[7] & o2[7] & d[7]);
      // Carry form only clears Z, so multi-byte compares chain correctly
      f = {f[7:6], h[4], d[7] ^ ov, ov, d[7],
        d[7:0] == 8'h0 && (op != `OP_COMPARE_WITH_CARRY || f[1]), d[8]};
      // Compares never redirect flow, so execution falls to the next word
      pe = pc_in + 22'h1;
      {cy, fl_ok, pc_ok} = {3'h1, 1'b1, 1'b1};
    end else begin
      pe = op == 6'h1c ? {6'h0, z_ptr} : op == 6'h1d ? {extended_indirect_high, z_ptr}
        : op == 6'h1e ? call_target : top_e;
      cy = op < 6'h1e ? 3'h3 : op == 6'h1e ? 3'h4 : 3'h5;
      if (op < 6'h1f) top_e = pc_in + (op == 6'h1e ? 22'h2 : 22'h1);
      fl_ok = op == `OP_INTERRUPT_EXIT;
      pp = op < 6'h1f ? 2'b10 : 2'b01;
      f = f | 8'h80;
    end
    q.push_back({top_e, pp, fl_ok, f, cy, pc_ok, pe});
    start = 1'b1;
    @(negedge sys_clk);
  endtask
  always @(negedge sys_clk) begin : watch
    logic [58:0] e;
    if (!rst && done === 1'b1) begin
      if (q.size() == 0) begin
        errors = errors + 1;
        $display("ERROR done expected 0 seen 1");
      end else begin
        e = q.pop_front();
        if (e[22]) cmp_pc("pc_out", e[21:0], pc_out);
        cmp_b("cycles_used", {5'h0, e[25:23]}, {5'h0, cycles_used});
        cmp_b("flags_we", {7'h0, e[34]}, {7'h0, flags_we});
        if (e[34]) cmp_b("status_flags_out", e[33:26], status_flags_out);
        cmp_b("push_pop", {6'h0, e[36:35]}, {6'h0, push_req, pop_req});
        if (e[36]) cmp_pc("ret_addr", e[58:37], ret_addr);
        cmp_b("busy", 8'h1, {7'h0, busy});
      end
    end
  end
  always @(posedge sys_clk) begin
    cyc_n = cyc_n + 1;
    if (cyc_n == 10000) begin
      errors = errors + 1;
      results;
    end
  end
  initial begin
    {seed, errors, n_tests, cyc_n, top_e} = {32'h59f1, 32'h0, 32'h0, 32'h0, 22'h0};
    {rst, start} = 2'b10;
    {pc_in, call_target, k_offset, bit_sel, next_two_word, rd_val, rr_val, imm_val, io_val,
      status_flags_in, z_ptr, extended_indirect_high, op_sel} = '0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    for (i = 0; i < 33; i++) issue(i[5:0]);
    for (i = 0; i < 600; i++) begin
      r = $unsigned($random(seed)) % 33;
      issue(r[5:0]);
    end
    start = 1'b0;
    repeat (10) @(negedge sys_clk);
    if (q.size() != 0) cmp_b("pending", 8'h0, 8'h1);
    cmp_b("busy_idle", 8'h0, {7'h0, busy});
    cmp_b("ready_idle", 8'h1, {7'h0, ready});
    // Second reset once the unit is idle: registered results clear, unit accepts at once after release
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    cmp_pc("pc_out_rst", 22'h0, pc_out);
    cmp_b("cycles_rst", 8'h0, {5'h0, cycles_used});
    cmp_b("flags_we_rst", 8'h0, {7'h0, flags_we});
    cmp_b("ready_rst", 8'h1, {7'h0, ready});
    rst = 1'b0;
    issue(`OP_BRANCH_ZERO_SET);
    issue(`OP_COMPARE_REGS);
    start = 1'b0;
    repeat (8) @(negedge sys_clk);
    if (q.size() != 0) cmp_b("pending_rst", 8'h0, 8'h1);
    results;
  end
endmodule // branch_skip_compare_unit_bench
